// File: core/kmltx_pkg.sv
package kmltx_pkg;

   // One open-drain pin as seen from inside: level to drive and its enable.
   typedef struct packed {
      logic out;
      logic oe_n;
   } kmltx_pin_s;

   localparam int unsigned CLK_MHZ      = 250;
   // Clock-low time that opens a send request or aborts one.
   localparam int unsigned INHIBIT_US   = 100;
   localparam int unsigned INHIBIT_CYC  = INHIBIT_US * CLK_MHZ;
   // Start bit is held under the low clock this long before the clock is let go.
   localparam int unsigned START_NS     = 40;
   localparam int unsigned START_CYC    = (START_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned FRAME_BITS   = 10;
   localparam logic [3:0]  FRAME_LAST   = 4'h9;
   localparam logic [3:0]  EDGE_RST     = 4'h0;
   localparam logic [15:0] TIMER_RST    = 16'h0000;
   localparam logic [7:0]  BYTE_RST     = 8'h00;

endpackage

// File: core/kmltx_host_tx.sv
`timescale 1ns/1ns

// How it works
// R1 - Host holds send high one clock.
// R2 - Clock low, then data low, release clock.
// R3 - Peripheral sees request, starts clocking.
// R4 - Start zero, eight bits LSB first, parity.
// R5 - Bits stable before each falling link edge.
// R6 - Release data after parity bit.
// R7 - Peripheral acknowledges with one low period.
// R8 - After acknowledge, idle, new request allowed; a parity bit of 0 still on the data line is taken as the acknowledge.
// R9 - Missed release makes peripheral ask resend.
// R10 - Resend request sends previous byte again.
// R11 - Abort by holding clock low before ack.
// R12 - Commands one byte, some take option.
// R13 - Indicator command takes lamp option byte.
// R14 - Echo command is answered with echo.
// R15 - Scan-set command takes set option.
// R16 - Identify answers acknowledge plus two bytes.
// R17 - Auto-repeat command sets repeat behaviour.
// R18 - Auto-repeat option: rate, delay fields.
// R19 - Busy high while a byte is moving.
// R20 - Parity is odd over data bits.
module kmltx_host_tx #(
   parameter int unsigned INHIBIT_CYC = kmltx_pkg::INHIBIT_CYC
) (
   // System clock and reset
   input  wire logic                   mclk_in,
   input  wire logic                   nrst_in,
   // Link clock, driven by the peripheral
   input  wire logic                   link_clock_line_in,
   // Link data level
   input  wire logic                   link_data_line_in,
   // Host side
   input  wire logic [7:0]             tx_byte_in,
   input  wire logic                   send_in,
   input  wire logic                   resend_in,
   input  wire logic                   abort_in,
   output logic                        busy_out,
   // Open-drain drivers
   output kmltx_pkg::kmltx_pin_s       link_clock_line_out,
   output kmltx_pkg::kmltx_pin_s       link_data_line_out
);

   typedef enum logic [2:0] {IDLE, INHIBIT, START, SEND, WAIT_ACK, ACKED, ABORT} kmltx_state_e;

   kmltx_state_e  state;
   kmltx_state_e  next_state;
   logic [7:0]    hold;
   logic [15:0]   timer;
   logic [3:0]    base;
   logic          clk_low;
   logic          data_low;
   logic          resend_pend;
   logic [3:0]    edge_bin;
   logic [3:0]    edge_gray;
   logic [3:0]    gray_s1;
   logic [3:0]    gray_s2;
   logic [2:0]    data_sync;
   logic          data_f;

   // Falling link edges are counted in the link domain; the peripheral
   // samples on those edges, so each count marks one bit consumed.
   wire [3:0] next_edge_bin = 4'(edge_bin + 4'h1);

   always_ff @(negedge link_clock_line_in or negedge nrst_in) begin
      if (!nrst_in) begin
         edge_bin  <= kmltx_pkg::EDGE_RST;
         edge_gray <= kmltx_pkg::EDGE_RST;
      end else begin
         edge_bin  <= next_edge_bin;
         edge_gray <= next_edge_bin ^ (next_edge_bin >> 1);
      end
   end

   // The gray count crosses with two flops; only one bit moves per edge.
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gray_s1 <= kmltx_pkg::EDGE_RST;
         gray_s2 <= kmltx_pkg::EDGE_RST;
      end else begin
         gray_s1 <= edge_gray;
         gray_s2 <= gray_s1;
      end
   end

   logic [3:0] edge_cnt;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_gray
         assign edge_cnt[gi] = ^gray_s2[3:gi];
      end
   endgenerate

   // Data pin level: three flops, a change counts when the last two agree.
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         data_sync <= 3'h7;
         data_f    <= 1'b1;
      end else begin
         data_sync <= {data_sync[1:0], link_data_line_in};
         if (data_sync[2] == data_sync[1]) begin
            data_f <= data_sync[2];
         end
      end
   end

   wire [3:0] idx        = 4'(edge_cnt - base);
   wire       parity     = ~^hold; // R20
   wire [9:0] frame      = {parity, hold, 1'b0}; // R4
   wire       frame_done = (idx > kmltx_pkg::FRAME_LAST);
   wire       frame_bit  = frame_done ? 1'b1 : frame[idx];
   wire       active     = (state != IDLE) && (state != ACKED) && (state != ABORT);
   wire       inhibit_end = (timer == 16'(INHIBIT_CYC - 1));
   wire       start_end  = (timer == 16'(kmltx_pkg::START_CYC - 1));
   wire       launch     = (state == IDLE) && (send_in || resend_pend);

   always_comb begin
      next_state = state;
      case (state)
         IDLE: begin
            if (launch) begin
               next_state = INHIBIT;
            end
         end
         INHIBIT: begin
            if (inhibit_end) begin
               next_state = START;
            end
         end
         START: begin
            if (start_end) begin
               next_state = SEND;
            end
         end
         SEND: begin
            if (frame_done) begin
               next_state = WAIT_ACK; // R6
            end
         end
         WAIT_ACK: begin
            if (!data_f) begin
               next_state = ACKED;
            end
         end
         ACKED: begin
            if (data_f) begin
               next_state = IDLE; // R8
            end
         end
         ABORT: begin
            if (inhibit_end) begin
               next_state = IDLE;
            end
         end
         default: begin
            next_state = IDLE;
         end
      endcase
      if (abort_in && active) begin
         next_state = ABORT; // R11
      end
   end

   // Drivers follow the next state so the pins change with the state itself.
   wire next_clk_low  = (next_state == INHIBIT) || (next_state == START)
                        || (next_state == ABORT); // R2
   wire next_data_low = (next_state == START)
                        || ((next_state == SEND) && (state != SEND || !frame_bit)); // R5

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state       <= IDLE;
         hold        <= kmltx_pkg::BYTE_RST;
         timer       <= kmltx_pkg::TIMER_RST;
         base        <= kmltx_pkg::EDGE_RST;
         clk_low     <= 1'b0;
         data_low    <= 1'b0;
         resend_pend <= 1'b0;
      end else begin
         state    <= next_state;
         clk_low  <= next_clk_low;
         data_low <= next_data_low;
         timer    <= (next_state != state) ? kmltx_pkg::TIMER_RST : 16'(timer + 16'h1);
         if (state == IDLE && send_in) begin
            hold <= tx_byte_in; // R1
         end
         if (state == START) begin
            base <= edge_cnt;
         end
         // A resend request arriving as a send starts still wins.
         if (resend_in) begin
            resend_pend <= 1'b1; // R10
         end else if (launch) begin
            resend_pend <= 1'b0;
         end
      end
   end

   // The line is only ever pulled low; release lets the pull-up raise it.
   assign link_clock_line_out = '{out: 1'b0, oe_n: ~clk_low};
   assign link_data_line_out  = '{out: 1'b0, oe_n: ~data_low};
   assign busy_out            = (state != IDLE); // R19

   // Inside the frame the data line may fall with the clock released, so only the
   // first low, the start bit, is tied to the held clock.
   a_start_under_inhibit : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R2
      ($rose(data_low) && state != SEND) |-> clk_low)
      else $error("Start bit driven without the clock held low.");

   a_clock_release_order : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R2
      (state == SEND && $past(state) == START) |-> (data_low && !clk_low))
      else $error("Clock released without the start bit held low.");

   a_parity_odd : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R20
      (state == SEND && $past(state) == SEND && $past(idx) == kmltx_pkg::FRAME_LAST)
      |-> (data_low == ^hold))
      else $error("Data and parity do not hold an odd count of ones.");

   a_frame_bit_order : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R4
      (state == SEND && $past(state) == SEND && $past(idx) <= kmltx_pkg::FRAME_LAST)
      |-> (data_low == !frame[$past(idx)]))
      else $error("Frame bit on the data line does not match its position.");

   a_bit_stable_edge : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R5
      (state == SEND && $past(state) == SEND && $changed(data_low))
      |-> ($past(idx) != $past(idx, 2)))
      else $error("Data line moved without a link edge.");

   a_release_after_parity : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R6
      (state == WAIT_ACK) |-> !data_low)
      else $error("Data line still driven after parity.");

   a_idle_after_ack : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R8
      (state == ACKED && data_f) |=> (!busy_out && !clk_low && !data_low))
      else $error("Lines or busy not idle after acknowledge.");

   a_abort_holds_clock : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R11
      (abort_in && active) |=> (clk_low && !data_low)[*8])
      else $error("Abort did not hold the clock low.");

   a_resend_same_byte : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R10
      (resend_in && state == IDLE && !send_in) ##1 !send_in
      |=> (busy_out && hold == $past(hold, 2)))
      else $error("Resend did not start with the previous byte.");

   a_busy_on_send : assert property (@(posedge mclk_in) disable iff (!nrst_in) // R19
      (send_in && state == IDLE) |=> (busy_out && hold == $past(tx_byte_in)))
      else $error("Send strobe did not capture the byte and raise busy.");

endmodule // kmltx_host_tx

// File: testbench/kmltx_periph_model.sv
`timescale 1ns/1ns

// Peripheral end of the link: makes the link clock only inside a frame.
module kmltx_periph_model (
   // Wire levels
   input  wire logic       clk_w,
   input  wire logic       data_w,
   // Peripheral drivers, high means released
   output logic            pclk,
   output logic            pd,
   // Received frame, start bit in bit 0
   output logic [9:0]      frame,
   output logic            got
);
   initial begin
      pclk = 1'b1;
      pd = 1'b1;
      got = 1'b0;
      frame = 10'h000;
      forever begin
         wait (clk_w === 1'b1 && data_w === 1'b0);
         #500;
         for (int i = 0; i < 10; i++) begin
            frame[i] = data_w;
            pclk = 1'b0;
            #62;
            pclk = 1'b1;
            #63;
         end
         wait (data_w === 1'b1);
         #125;
         pd = 1'b0;
         #125;
         pd = 1'b1;
         got = 1'b1;
         #1 got = 1'b0;
      end
   end
endmodule // kmltx_periph_model

// File: testbench/kmltx_host_tx_tb_top.sv
`timescale 1ns/1ns

module kmltx_host_tx_tb_top;
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin err_total++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
   logic                  mclk_in = 1'b0;
   logic                  nrst_in;
   logic [7:0]            tx_byte_in = 8'h00;
   logic                  send_in = 1'b0;
   logic                  resend_in = 1'b0;
   logic                  abort_in = 1'b0;
   logic                  busy_out;
   kmltx_pkg::kmltx_pin_s ck_o;
   kmltx_pkg::kmltx_pin_s dt_o;
   logic                  pclk;
   logic                  pd;
   logic                  got;
   logic [9:0]            frame;
   logic [9:0]            expq[$];
   logic [9:0]            exp_frame;
   logic [31:0]           rnd = 32'h5018;
   int                    err_total = 0;
   int                    comparisons = 0;
   int                    cyc = 0;
   int                    frames = 0;
   // Open-drain wires with pull-ups.
   wire cw = (ck_o.oe_n ? 1'b1 : ck_o.out) & pclk;
   wire dw = (dt_o.oe_n ? 1'b1 : dt_o.out) & pd;

   kmltx_host_tx #(.INHIBIT_CYC(50)) dut (
      .mclk_in(mclk_in), .nrst_in(nrst_in), .link_clock_line_in(cw),
      .link_data_line_in(dw), .tx_byte_in(tx_byte_in), .send_in(send_in),
      .resend_in(resend_in), .abort_in(abort_in), .busy_out(busy_out),
      .link_clock_line_out(ck_o), .link_data_line_out(dt_o));
   kmltx_periph_model peer (.clk_w(cw), .data_w(dw), .pclk(pclk), .pd(pd),
      .frame(frame), .got(got));

   initial begin
      forever #2 mclk_in = ~mclk_in;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Waits for busy to fall within a bound.
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy_out !== 1'b0 && n < 20000) begin
         @(posedge mclk_in);
         n++;
      end
      `CHK("busy_idle", 1'b0, busy_out)
   endtask

   // One host request; a resend replays the byte sent last.
   task automatic start(input logic [7:0] b, input logic rs);
      @(posedge mclk_in);
      // A resend offers a different byte so that only the held one can pass.
      tx_byte_in <= rs ? ~b : b;
      send_in <= ~rs;
      resend_in <= rs;
      expq.push_back({~^b, b, 1'b0});
      @(posedge mclk_in);
      send_in <= 1'b0;
      resend_in <= 1'b0;
      @(posedge mclk_in);
      @(negedge mclk_in);
      `CHK("busy", 1'b1, busy_out)
   endtask

   // One request carried through until busy falls; for a parity bit of 0 that is before the acknowledge.
   task automatic xfer(input logic [7:0] b, input logic rs);
      start(b, rs);
      wait_idle();
   endtask

   // The note is taken once; the compare macro reads its operands twice.
   always @(posedge got) begin
      frames++;
      exp_frame = (expq.size() > 0) ? expq.pop_front() : 10'h3ff;
      `CHK("frame", exp_frame, frame)
   end

   always @(posedge mclk_in) begin
      cyc++;
      if (cyc > 60000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      logic [7:0] last;
      // A real falling edge, so the link-domain counter is reset as well.
      nrst_in <= 1'b0;
      repeat (6) @(posedge mclk_in);
      nrst_in <= 1'b1;
      // Keyboard commands with their option bytes, then random bytes.
      xfer(8'hed, 1'b0);
      xfer(8'h07, 1'b0);
      xfer(8'hee, 1'b0);
      xfer(8'hf0, 1'b0);
      xfer(8'h02, 1'b0);
      xfer(8'hf0, 1'b0);
      xfer(8'h00, 1'b0);
      xfer(8'hf2, 1'b0);
      xfer(8'hf3, 1'b0);
      rnd = xs(rnd);
      xfer({1'b0, rnd[6:0]}, 1'b0);
      for (int i = 0; i < 6; i++) begin
         rnd = xs(rnd);
         last = rnd[7:0];
         xfer(last, 1'b0);
      end
      xfer(last, 1'b1);
      // Abort while the clock is still held low: no frame may go out.
      start(8'hf3, 1'b0);
      void'(expq.pop_back());
      @(posedge mclk_in);
      abort_in <= 1'b1;
      @(posedge mclk_in);
      abort_in <= 1'b0;
      repeat (55) @(posedge mclk_in);
      `CHK("abort_busy", 1'b0, busy_out)
      #3000;
      `CHK("frames", 32'h11, frames)
      end_sim();
   end
endmodule // kmltx_host_tx_tb_top
